// [src/lps_map.vh]
`ifndef LPS_MAP_VH
`define LPS_MAP_VH
// Data width of both registers
`define LPS_WIDTH 8
// Reset value of the storage register
`define LPS_STORE_RST 8'h00
// Reset value of the shift register
`define LPS_SHIFT_RST 8'h00
// Entries in the output buffer
`define LPS_BUF_DEPTH 2
// Idle levels of the control synchronisers: clear and load inactive
`define LPS_CTL_RST 5'h18
// Bit count at which the eighth shift completes a word
`define LPS_LAST_BIT 3'h7
`endif

// [src/lps_buf.v]
`default_nettype none
// Two-entry valid/ready buffer; a word offered while both entries are full is not stored
module lps_buf #(
  parameter WIDTH = 8
) (
  input wire clk_sys,
  input wire reset,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_q [0:1];
  reg wr_q;
  reg rd_q;
  reg [1:0] cnt_q;
  wire push;
  wire pop;

  assign push = in_valid && (cnt_q != 2'd2);
  assign pop = out_valid && out_ready;
  assign in_ready = (cnt_q != 2'd2);
  assign out_valid = (cnt_q != 2'd0);
  assign out_data = mem_q[rd_q];

  // Pointer and count update
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'd0;
      mem_q[0] <= {WIDTH{1'b0}};
      mem_q[1] <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        mem_q[wr_q] <= in_data;
        wr_q <= ~wr_q;
      end
      if (pop)
        rd_q <= ~rd_q;
      if (push && !pop)
        cnt_q <= cnt_q + 2'd1;
      else if (pop && !push)
        cnt_q <= cnt_q - 2'd1;
    end
  end
endmodule // lps_buf
`default_nettype wire

// [src/lps_top.v]
// Behaviour
// - Eight-bit storage register feeds a separate eight-bit shift register.
// - Latch clock rising edge captures parallel inputs, ignoring other controls.
// - Without latch clock rising edge the storage register holds.
// - Load low, clear inactive: shift register follows storage continuously.
// - Serial input accepted only with load high, on shift clock rises.
// - Shift edge: first stage takes serial input, others take predecessor.
// - Shifting spans exactly eight stages on shift clock rising edge.
// - Clear and load high without shift edge: shift register holds.
// - Clear low forces shift register to zero after the two-flop synchroniser delay; storage untouched.
`include "lps_map.vh"
`default_nettype none
module lps_top #(
  parameter WIDTH = `LPS_WIDTH
) (
  input wire clk_sys,
  input wire reset,
  input wire [WIDTH-1:0] par_in,
  input wire input_latch_clock,
  input wire shift_clock,
  input wire serial_in,
  input wire parallel_load_n,
  input wire shift_clear_n,
  output reg serial_out,
  output reg [WIDTH-1:0] shift_word,
  output reg word_valid,
  input wire word_ready,
  output reg [WIDTH-1:0] word_data
);
  // Shift register modes, lowest priority first
  localparam [1:0] MODE_HOLD = 2'h0;
  localparam [1:0] MODE_SHIFT = 2'h1;
  localparam [1:0] MODE_LOAD = 2'h2;
  localparam [1:0] MODE_CLEAR = 2'h3;

  // Two-flop synchroniser stages for the parallel data pins
  reg [WIDTH-1:0] par_s1_q;
  reg [WIDTH-1:0] par_s2_q;

  // Two-flop synchroniser stages for the five control pins
  reg [4:0] ctl_s1_q;
  reg [4:0] ctl_s2_q;

  // Previous synchronised clock levels for edge detection
  reg rck_old_q;
  reg sck_old_q;

  // Storage register, and shift register with its next value
  reg [WIDTH-1:0] store_q;
  reg [WIDTH-1:0] shift_q;
  reg [WIDTH-1:0] shift_d;

  // Shifts since the last clear or load, and the word strobe
  reg [2:0] bit_cnt_q;
  reg [2:0] bit_cnt_d;
  reg word_push;
  reg word_push_d;

  // Decoded mode of the current cycle
  reg [1:0] mode;

  // Synchronised pin levels and detected edges
  wire rck_rise;
  wire sck_rise;
  wire si_s;
  wire load_n_s;
  wire clr_n_s;

  // Shifted-by-one view of the shift register
  wire [WIDTH-1:0] shift_fwd;

  // Word buffer handshake
  wire buf_in_ready;
  wire buf_out_valid;
  wire [WIDTH-1:0] buf_out_data;

  genvar gi;

  // Rising edge of a synchronised level against its previous sample
  function lps_rise;
    input cur;
    input old;
    begin
      lps_rise = cur & ~old;
    end
  endfunction

  // Priority decode: clear over load over shift edge over hold
  function [1:0] lps_mode;
    input clr_n;
    input load_n;
    input rise;
    begin
      if (!clr_n)
        lps_mode = MODE_CLEAR;
      else if (!load_n)
        lps_mode = MODE_LOAD;
      else if (rise)
        lps_mode = MODE_SHIFT;
      else
        lps_mode = MODE_HOLD;
    end
  endfunction

  // Edge detectors read only the second synchroniser stage
  assign rck_rise = lps_rise(ctl_s2_q[0], rck_old_q);
  assign sck_rise = lps_rise(ctl_s2_q[1], sck_old_q);
  assign si_s = ctl_s2_q[2];
  assign load_n_s = ctl_s2_q[3];
  assign clr_n_s = ctl_s2_q[4];

  // Synchroniser stages and edge history
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      par_s1_q <= `LPS_STORE_RST;
      par_s2_q <= `LPS_STORE_RST;
      ctl_s1_q <= `LPS_CTL_RST;
      ctl_s2_q <= `LPS_CTL_RST;
      rck_old_q <= 1'b0;
      sck_old_q <= 1'b0;
    end else begin
      par_s1_q <= par_in;
      par_s2_q <= par_s1_q;
      ctl_s1_q <= {shift_clear_n, parallel_load_n, serial_in,
                   shift_clock, input_latch_clock};
      ctl_s2_q <= ctl_s1_q;
      rck_old_q <= ctl_s2_q[0];
      sck_old_q <= ctl_s2_q[1];
    end
  end

  // Storage register, independent of load and clear
  always @(posedge clk_sys or posedge reset) begin
    if (reset)
      store_q <= `LPS_STORE_RST;
    else if (rck_rise)
      store_q <= par_s2_q;
    // Otherwise holds
  end

  // Stage inputs of a shift: first takes serial data, others the one below
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_stage
      if (gi == 0) begin : g_first
        assign shift_fwd[gi] = si_s;
      end else begin : g_next
        assign shift_fwd[gi] = shift_q[gi-1];
      end
    end
  endgenerate

  // Next shift state for the decoded mode
  always @* begin
    mode = lps_mode(clr_n_s, load_n_s, sck_rise);
    shift_d = shift_q;
    bit_cnt_d = bit_cnt_q;
    word_push_d = 1'b0;
    case (mode)
      MODE_CLEAR: begin
        shift_d = `LPS_SHIFT_RST;
        bit_cnt_d = 3'h0;
      end
      MODE_LOAD: begin
        shift_d = store_q;
        bit_cnt_d = 3'h0;
      end
      MODE_SHIFT: begin
        shift_d = shift_fwd;
        bit_cnt_d = bit_cnt_q + 3'h1;
        word_push_d = (bit_cnt_q == `LPS_LAST_BIT);
      end
      default: begin
        shift_d = shift_q;
      end
    endcase
  end

  // Shift register state; the eighth shift pushes the word
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      shift_q <= `LPS_SHIFT_RST;
      bit_cnt_q <= 3'h0;
      word_push <= 1'b0;
    end else begin
      shift_q <= shift_d;
      bit_cnt_q <= bit_cnt_d;
      word_push <= word_push_d;
    end
  end

  // Clear acts through the synchroniser, so it is seen two cycles late;
  // a pulse shorter than one system clock may be missed entirely.

  // Registered outputs
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      serial_out <= 1'b0;
      shift_word <= `LPS_SHIFT_RST;
      word_valid <= 1'b0;
      word_data <= `LPS_SHIFT_RST;
    end else begin
      serial_out <= shift_q[WIDTH-1];
      shift_word <= shift_q;
      word_valid <= buf_out_valid && !(word_valid && word_ready);
      word_data <= buf_out_data;
    end
  end

  // Buffer of completed eight-bit serial words; one completed while both entries are full is dropped
  lps_buf #(.WIDTH(WIDTH)) u_buf (
    .clk_sys(clk_sys),
    .reset(reset),
    .in_valid(word_push),
    .in_ready(buf_in_ready),
    .in_data(shift_q),
    .out_valid(buf_out_valid),
    .out_ready(word_valid && word_ready),
    .out_data(buf_out_data)
  );
endmodule // lps_top
`default_nettype wire

// [tb/lps_checker.sv]
`default_nettype none
module lps_checker (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic input_latch_clock,
  input wire logic shift_clock,
  input wire logic parallel_load_n,
  input wire logic shift_clear_n,
  input wire logic serial_out,
  input wire logic word_valid,
  input wire logic word_ready,
  input wire logic [7:0] shift_word,
  input wire logic [7:0] word_data
);
  timeunit 1ns / 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Short aliases for the control levels and the shift word
  wire logic c = shift_clear_n, l = parallel_load_n, k = input_latch_clock;
  wire logic [7:0] s = shift_word;
  property p_c; (!c && l) [*6] |-> !s; endproperty
  a_c: assert property (p_c) else $error("clear");
  property p_b; (!c && !l) [*6] |-> !s; endproperty
  a_b: assert property (p_b) else $error("both");
  property p_h; (c && l && !shift_clock) [*8] |-> $stable(s); endproperty
  a_h: assert property (p_h) else $error("hold");
  property p_l; (c && !l && !k) [*8] |-> $stable(s); endproperty
  a_l: assert property (p_l) else $error("load");
  property p_o; serial_out == s[7]; endproperty
  a_o: assert property (p_o) else $error("out");
  property p_s; word_valid && !word_ready |=> $stable(word_data); endproperty
  a_s: assert property (p_s) else $error("stall");
  property p_f; $fell(word_valid) |-> $past(word_ready); endproperty
  a_f: assert property (p_f) else $error("drop");
  property p_m; (c && l) [*8] ##0 $changed(s) |-> s[7:1] == $past(s[6:0]);
  endproperty
  a_m: assert property (p_m) else $error("shift");
endmodule // lps_checker
bind lps_top lps_checker u_lps_checker (.*);
`default_nettype wire

// [tb/lps_host.sv]
`default_nettype none
module lps_host (input wire logic clk_sys, output logic [12:0] pins);
  timeunit 1ns / 1ns;
  initial pins = 13'h0003;
  // Pins change after an edge and stand three cycles
  task automatic put(input logic [12:0] v);
    @(posedge clk_sys);
    pins <= v;
    repeat (2) @(posedge clk_sys);
  endtask
endmodule // lps_host
`default_nettype wire

// [tb/lps_top_tb.sv]
`default_nettype none
module lps_top_tb;
  timeunit 1ns / 1ns;
  logic clk_sys = 1'b0, reset = 1'b1, word_ready = 1'b0;
  logic [7:0] m = 8'h00, a, st, q[$];
  logic [31:0] x = 32'he7de;
  int mismatches = 0, check_count = 0, n = 0;
  wire logic [12:0] p;
  wire logic serial_out, word_valid;
  wire logic [7:0] shift_word, word_data;
  always #50 clk_sys = ~clk_sys;
  lps_host u_lps_host (.clk_sys, .pins(p));
  lps_top u_lps_top (.clk_sys, .reset, .par_in(p[12:5]),
    .input_latch_clock(p[4]), .shift_clock(p[3]), .serial_in(p[2]),
    .parallel_load_n(p[1]), .shift_clear_n(p[0]), .serial_out, .shift_word,
    .word_valid, .word_ready, .word_data);
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  task automatic chk(input logic [7:0] s, e);
    check_count++;
    mismatches += (s !== e);
    if (s !== e) $display("unexpected %0t seen %h want %h", $time, s, e);
  endtask
  // Drive controls, let the pipeline settle, compare with the model
  task automatic go(input logic [4:0] c, logic [7:0] e);
    u_lps_host.put({a, c});
    m = e;
    repeat (4) @(posedge clk_sys);
    chk(shift_word, m);
    chk({7'h00, serial_out}, {7'h00, m[7]});
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Accepted words leave in model order
  always @(posedge clk_sys)
    if (word_valid && word_ready) chk(word_data, q.pop_front());
  initial begin
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    x = xs(x);
    a = x[7:0];
    st = a;
    go(5'h03, 8'h00);
    go(5'h13, 8'h00);
    a = ~a;
    go(5'h09, st);
    go(5'h01, st);
    go(5'h09, st);
    go(5'h0b, st);
    repeat (16) begin
      x = xs(x);
      go({2'b00, x[0], 2'h3}, m);
      go({2'b01, x[0], 2'h3}, {m[6:0], x[0]});
      go({2'b00, ~x[0], 2'h3}, m);
      if (++n % 8 == 0) q.push_back(m);
    end
    chk({7'h00, word_valid}, 8'h01);
    word_ready <= 1'b1;
    for (int i = 0; i < 20 && q.size() > 0; i++) @(posedge clk_sys);
    chk(8'(q.size()), 8'h00);
    go(5'h02, 8'h00);
    go(5'h01, st);
    go(5'h00, 8'h00);
    print_verdict();
  end
endmodule // lps_top_tb
`default_nettype wire
